// >>> design/smsp_pkg.sv
// Constants and register map of the serial master/slave port
package smsp_pkg;
  localparam int ADDR_W = 12;
  // Register indices; byte address is four times the index
  localparam logic [7:0] CTRL_IDX = 8'hF3;
  localparam logic [7:0] STAT_IDX = 8'hF4;
  localparam logic [7:0] DATA_IDX = 8'hF5;
  localparam logic [ADDR_W-1:0] CTRL_ADDR = {2'b00, CTRL_IDX, 2'b00};
  localparam logic [ADDR_W-1:0] STAT_ADDR = {2'b00, STAT_IDX, 2'b00};
  localparam logic [ADDR_W-1:0] DATA_ADDR = {2'b00, DATA_IDX, 2'b00};
  // Control fields
  localparam int CTRL_AUTO_SS = 7;
  localparam int CTRL_EN = 6;
  localparam int CTRL_LSB = 5;
  localparam int CTRL_MASTER_SELECT = 4;
  localparam int CTRL_CLOCK_IDLE_LEVEL = 3;
  localparam int CTRL_SAMPLE_EDGE_SELECT = 2;
  localparam int CTRL_RATE_HI = 1;
  localparam int CTRL_RATE_LO = 0;
  // Status fields
  localparam int STAT_DONE = 7;
  localparam int STAT_WCOL = 6;
  localparam int STAT_OVF = 5;
  localparam int STAT_FAULT = 4;
  localparam int STAT_FDIS = 3;
  // Reset values
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] STAT_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;
  // Timing: shift clock divisors, half periods in hclk cycles
  localparam int CLK_MHZ = 200;
  localparam int DIV_0 = 16;
  localparam int DIV_1 = 32;
  localparam int DIV_2 = 64;
  localparam int DIV_3 = 128;
  localparam logic [6:0] HALF_0 = 7'(DIV_0 / 2);
  localparam logic [6:0] HALF_1 = 7'(DIV_1 / 2);
  localparam logic [6:0] HALF_2 = 7'(DIV_2 / 2);
  localparam logic [6:0] HALF_3 = 7'(DIV_3 / 2);
  localparam logic [3:0] LAST_EDGE = 4'hF;
  // Bus encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
endpackage : smsp_pkg

// >>> design/smsp_sync.sv
// Two flip-flop level synchroniser
module smsp_sync #(
  parameter logic RESET_VAL = 1'b0
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic d,
  output logic q
);
  logic meta;
  logic next_meta;
  logic next_q;

  // Next values
  always_comb begin
    next_meta = d;
    next_q = meta;
  end

  // Registers; first stage feeds only the second
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta <= RESET_VAL;
      q <= RESET_VAL;
    end else begin
      meta <= next_meta;
      q <= next_q;
    end
  end
endmodule : smsp_sync

// >>> design/smsp_rate_div.sv
// Shift clock divider: one tick per half period while running
module smsp_rate_div
  import smsp_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic run,
  input wire logic [1:0] rate_sel,
  output logic tick
);
  logic [6:0] cnt;
  logic [6:0] next_cnt;
  logic [6:0] half;

  // Half period and counter
  always_comb begin
    unique case (rate_sel)
      2'b00: half = HALF_0;
      2'b01: half = HALF_1;
      2'b10: half = HALF_2;
      2'b11: half = HALF_3;
    endcase
    tick = run && (cnt == half - 7'h01);
    if (!run || tick) begin
      next_cnt = 7'h00;
    end else begin
      next_cnt = cnt + 7'h01;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt <= 7'h00;
    end else begin
      cnt <= next_cnt;
    end
  end
endmodule : smsp_rate_div

// >>> design/smsp_port.sv
// Serial master/slave port with AHB-Lite register slave
// Behaviour
// - One shifter for transmit, read buffer for receive
// - No shifter load during a transfer
// - Finished byte copied to read buffer unless done still set
// - Master drives out line, slave reads it
// - Shift clock output as master, input as slave
// - Eight shift clock cycles per transfer
// - Slave active only while select low
// - Master select pin is GPIO or fault input
// - Full duplex exchange of shifter contents
// - MSB first default, LSB first by control
// - Control resets zero, bit 6 enables port
// - Control bit 4 selects master or slave
// - Control bit 3 sets clock idle level
// - Control bit 2 selects sampling edge
// - Control bits 1:0 select divide 16..128
// - Bit 7 acts only master, fault detect off
// - Auto select low per byte, high idle
// - Master data write starts a transfer
// - Done flag set; writes ignored while set
// - Select low in master sets fault flag
//
// Added by the designer: the AHB-Lite interface to the registers.
module smsp_port
  import smsp_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [smsp_pkg::ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic mosi_in,
  output logic mosi_out,
  output logic mosi_oe_n,
  input wire logic miso_in,
  output logic miso_out,
  output logic miso_oe_n,
  input wire logic shift_clock_pin_in,
  output logic shift_clock_pin_out,
  output logic shift_clock_pin_oe_n,
  input wire logic select_n_in,
  output logic select_n_out,
  output logic select_n_oe_n
);
  import smsp_pkg::*;

  logic [7:0] ctrl, next_ctrl;
  logic done, next_done, wcol, next_wcol;
  logic ovf, next_ovf, fault, next_fault;
  logic fdis, next_fdis;
  logic [7:0] shifter, next_shifter;
  logic [7:0] read_buf, next_read_buf;
  logic rx_bit, next_rx_bit;
  logic [3:0] edge_cnt, next_edge_cnt;
  logic busy, next_busy;
  logic sclk_q, next_sclk_q;
  logic sclk_d, next_sclk_d;
  logic out_bit, next_out_bit, sel_q, next_sel_q;
  logic dp_write, dp_read, next_dp_write, next_dp_read;
  logic [ADDR_W-1:0] dp_addr, next_dp_addr;
  logic sclk_s, ss_s, tick;
  logic master_mode, slave_mode, ss_sel, sample_edge_select, lsb;
  logic m_edge, s_edge, edge_ev, sample, do_shift, last;
  logic in_bit, shift_bit, wr_data, wr_ctrl, wr_stat, load_ok, auto_ss;
  logic [7:0] shifted;

  // Slave clock and select pass a synchroniser first
  smsp_sync #(.RESET_VAL(1'b0)) u_sclk_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .d(shift_clock_pin_in),
    .q(sclk_s)
  );
  smsp_sync #(.RESET_VAL(1'b1)) u_ss_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .d(select_n_in),
    .q(ss_s)
  );

  // Master half-period ticks
  smsp_rate_div u_div (
    .hclk(hclk),
    .hresetn(hresetn),
    .run(busy),
    .rate_sel(ctrl[CTRL_RATE_HI:CTRL_RATE_LO]),
    .tick(tick)
  );

  // Mode decode and shift events
  always_comb begin
    master_mode = ctrl[CTRL_EN] && ctrl[CTRL_MASTER_SELECT];
    slave_mode = ctrl[CTRL_EN] && !ctrl[CTRL_MASTER_SELECT];
    ss_sel = slave_mode && !ss_s;
    sample_edge_select = ctrl[CTRL_SAMPLE_EDGE_SELECT];
    lsb = ctrl[CTRL_LSB];
    m_edge = master_mode && busy && tick;
    s_edge = ss_sel && (sclk_s != sclk_d);
    edge_ev = m_edge || s_edge;
    last = edge_ev && (edge_cnt == LAST_EDGE);
    sample = edge_ev && (edge_cnt[0] == sample_edge_select);
    do_shift = (edge_ev && (edge_cnt[0] != sample_edge_select)
      && !(sample_edge_select && edge_cnt == 4'h0)) || (sample_edge_select && last);
    in_bit = master_mode ? miso_in : mosi_in;
    shift_bit = (sample_edge_select && last) ? in_bit : rx_bit;
    shifted = lsb ? {shift_bit, shifter[7:1]}
      : {shifter[6:0], shift_bit};
    wr_data = dp_write && (dp_addr == DATA_ADDR);
    wr_ctrl = dp_write && (dp_addr == CTRL_ADDR);
    wr_stat = dp_write && (dp_addr == STAT_ADDR);
    load_ok = wr_data && ctrl[CTRL_EN] && !busy
      && (edge_cnt == 4'h0) && !done;
    auto_ss = master_mode && fdis && ctrl[CTRL_AUTO_SS];
  end

  // AHB-Lite address phase capture
  always_comb begin
    next_dp_write = 1'b0;
    next_dp_read = 1'b0;
    next_dp_addr = dp_addr;
    if (hsel && hready && htrans == HTRANS_NONSEQ) begin
      next_dp_write = hwrite;
      next_dp_read = !hwrite;
      next_dp_addr = haddr;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_write <= 1'b0;
      dp_read <= 1'b0;
      dp_addr <= '0;
    end else begin
      dp_write <= next_dp_write;
      dp_read <= next_dp_read;
      dp_addr <= next_dp_addr;
    end
  end

  // Read data in the data phase; unmapped reads give zero
  always_comb begin
    hreadyout = 1'b1;
    hresp = 1'b0;
    hrdata = 32'h0000_0000;
    if (dp_read) begin
      unique case (dp_addr)
        CTRL_ADDR: hrdata = {24'h00_0000, ctrl};
        STAT_ADDR: hrdata = {24'h00_0000, done, wcol, ovf, fault, fdis,
          3'h0};
        DATA_ADDR: hrdata = {24'h00_0000, read_buf};
        default: hrdata = 32'h0000_0000;
      endcase
    end
  end

  // Control, status, shifter and sequencing next state
  always_comb begin
    next_ctrl = wr_ctrl ? hwdata[7:0] : ctrl;
    next_fdis = wr_stat ? hwdata[STAT_FDIS] : fdis;
    // Software writes zero to clear; hardware set wins
    next_done = done && !(wr_stat && !hwdata[STAT_DONE]);
    next_wcol = wcol && !(wr_stat && !hwdata[STAT_WCOL]);
    next_ovf = ovf && !(wr_stat && !hwdata[STAT_OVF]);
    next_fault = fault && !(wr_stat && !hwdata[STAT_FAULT]);
    next_shifter = shifter;
    next_read_buf = read_buf;
    next_rx_bit = rx_bit;
    next_edge_cnt = edge_cnt;
    next_busy = busy;
    next_sclk_q = busy ? sclk_q : ctrl[CTRL_CLOCK_IDLE_LEVEL];
    next_sclk_d = sclk_s;
    next_out_bit = out_bit;
    if (wr_data && (busy || edge_cnt != 4'h0)) begin
      next_wcol = 1'b1;
    end
    if (load_ok) begin
      next_shifter = hwdata[7:0];
      next_out_bit = lsb ? hwdata[0] : hwdata[7];
      next_edge_cnt = 4'h0;
      if (master_mode) begin
        next_busy = 1'b1;
        next_sclk_q = ctrl[CTRL_CLOCK_IDLE_LEVEL];
      end
    end
    if (m_edge) begin
      next_sclk_q = !sclk_q;
    end
    if (sample) begin
      next_rx_bit = in_bit;
    end
    if (do_shift) begin
      next_shifter = shifted;
      // Output bit holds across the last sampling edge
      if (!(sample_edge_select && last)) begin
        next_out_bit = lsb ? shifted[0] : shifted[7];
      end
    end
    if (edge_ev) begin
      next_edge_cnt = edge_cnt + 4'h1;
    end
    if (last) begin
      next_busy = 1'b0;
      next_edge_cnt = 4'h0;
      if (done) begin
        next_ovf = 1'b1;
      end else begin
        next_read_buf = shifted;
        next_done = 1'b1;
      end
    end
    if (slave_mode && ss_s) begin
      next_edge_cnt = 4'h0;
    end
    if (master_mode && !fdis && !ss_s) begin
      next_fault = 1'b1;
    end
    if (!ctrl[CTRL_EN]) begin
      next_busy = 1'b0;
      next_edge_cnt = 4'h0;
    end
    // Select stays low one cycle past the final clock edge
    next_sel_q = !(busy || next_busy);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl <= CTRL_RESET;
      {done, wcol, ovf, fault, fdis} <= STAT_RESET[7:3];
      shifter <= DATA_RESET;
      read_buf <= DATA_RESET;
      rx_bit <= 1'b0;
      edge_cnt <= 4'h0;
      busy <= 1'b0;
      sclk_q <= 1'b0;
      sclk_d <= 1'b0;
      out_bit <= 1'b0;
      sel_q <= 1'b1;
    end else begin
      ctrl <= next_ctrl;
      done <= next_done;
      wcol <= next_wcol;
      ovf <= next_ovf;
      fault <= next_fault;
      fdis <= next_fdis;
      shifter <= next_shifter;
      read_buf <= next_read_buf;
      rx_bit <= next_rx_bit;
      edge_cnt <= next_edge_cnt;
      busy <= next_busy;
      sclk_q <= next_sclk_q;
      sclk_d <= next_sclk_d;
      out_bit <= next_out_bit;
      sel_q <= next_sel_q;
    end
  end

  // Pin drivers; enables low while driving
  always_comb begin
    mosi_out = out_bit;
    miso_out = out_bit;
    mosi_oe_n = !master_mode;
    miso_oe_n = !ss_sel;
    shift_clock_pin_out = sclk_q;
    shift_clock_pin_oe_n = !master_mode;
    select_n_out = sel_q;
    select_n_oe_n = !auto_ss;
  end

  // Helper: master clock toggles within one transfer
  logic [4:0] tog_cnt;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tog_cnt <= 5'h00;
    end else if (load_ok) begin
      tog_cnt <= 5'h00;
    end else if (m_edge) begin
      tog_cnt <= tog_cnt + 5'h01;
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence master_start;
    load_ok && master_mode;
  endsequence

  sequence byte_done;
    last && !done;
  endsequence

  AST_NO_LOAD_BUSY: assert property (
    (wr_data && busy && !do_shift) |=> (shifter == $past(shifter)) && wcol)
    else $error("shifter loaded during transfer");
  AST_READ_BUF: assert property (
    byte_done |=> (read_buf == shifter) && done)
    else $error("received byte not in read buffer");
  AST_MASTER_PINS: assert property (
    master_mode |-> !mosi_oe_n && !shift_clock_pin_oe_n && miso_oe_n)
    else $error("master pin directions wrong");
  AST_EIGHT_CYCLES: assert property (
    (m_edge && edge_cnt == LAST_EDGE) |-> tog_cnt == 5'h0F)
    else $error("transfer not sixteen clock edges");
  AST_SLAVE_IDLE: assert property (
    (slave_mode && ss_s) |-> miso_oe_n ##1 edge_cnt == 4'h0)
    else $error("unselected slave active");
  AST_MSB_FIRST: assert property (
    (master_start and !lsb) |=> mosi_out == $past(hwdata[7]))
    else $error("first bit is not msb");
  AST_IDLE_LEVEL: assert property (
    (!busy && $past(!busy) && $stable(ctrl)) |->
      shift_clock_pin_out == ctrl[CTRL_CLOCK_IDLE_LEVEL])
    else $error("shift clock idle level wrong");
  AST_RATE16: assert property (
    (m_edge && ctrl[1:0] == 2'b00 && $stable(ctrl)) |=> !m_edge [*7])
    else $error("divide by sixteen half period short");
  AST_AUTO_SS: assert property (
    (master_start and auto_ss) |=> !select_n_out && !select_n_oe_n)
    else $error("auto select not low in transfer");
  AST_DONE_BLOCKS: assert property (
    (wr_data && done && !busy) |=> !busy && edge_cnt == 4'h0)
    else $error("data write accepted while done set");
  AST_FAULT: assert property (
    (master_mode && !fdis && !ss_s) |=> fault)
    else $error("mode fault not flagged");
endmodule : smsp_port

// >>> testbench/smsp_slave_model.sv
// Behavioural external serial slave facing the port in master mode
module smsp_slave_model (
  input wire logic sclk,
  input wire logic sel_n,
  input wire logic mosi,
  input wire logic clock_idle_level,
  input wire logic sample_edge_select,
  input wire logic [7:0] tx_byte,
  output logic miso,
  output logic [7:0] rx_byte,
  output int bits
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] sh;
  // Idle state before any frame
  initial begin
    miso = 1'b0;
    rx_byte = 8'h00;
    bits = 0;
    sh = 8'h00;
  end
  // Frame start loads the reply byte
  always @(negedge sel_n) begin
    sh = tx_byte;
    bits = 0;
    if (!sample_edge_select) miso = tx_byte[7];
  end
  // Released line shows the inverse of its last level
  always @(posedge sel_n) miso = ~miso;
  // Sample on one edge, shift out on the other
  always @(sclk) begin
    if (sel_n === 1'b0) begin
      if ((sclk != clock_idle_level) ^ sample_edge_select) begin
        sh = {sh[6:0], mosi};
        bits = bits + 1;
        rx_byte = sh;
      end else begin
        miso = sh[7];
      end
    end
  end
endmodule : smsp_slave_model

// >>> testbench/testbench.sv
// Self-checking bench for the serial master/slave port
module testbench;
  import smsp_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [ADDR_W-1:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, rdv;
  logic mosi_out, mosi_oe_n, miso_out, miso_oe_n, sck_out, sck_oe_n;
  logic sel_out, sel_oe_n, m_miso, tb_sel_n, clock_idle_level, sample_edge_select, sclk_q;
  logic [7:0] m_tx, m_rx;
  wire logic sclk_w, mosi_w, miso_w, sel_w;
  int m_bits, bad_count, samples_checked, cyc, edges, first, last;
  int dv[4] = '{DIV_0, DIV_1, DIV_2, DIV_3};
  // Pin levels resolved from the port's enables
  assign sclk_w = sck_oe_n ? 1'b0 : sck_out;
  assign mosi_w = mosi_oe_n ? 1'b1 : mosi_out;
  assign miso_w = miso_oe_n ? m_miso : miso_out;
  assign sel_w = sel_oe_n ? tb_sel_n : sel_out;
  assign hready = hreadyout;
  smsp_port u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .mosi_in(mosi_w),
    .mosi_out(mosi_out), .mosi_oe_n(mosi_oe_n), .miso_in(miso_w),
    .miso_out(miso_out), .miso_oe_n(miso_oe_n),
    .shift_clock_pin_in(sclk_w), .shift_clock_pin_out(sck_out),
    .shift_clock_pin_oe_n(sck_oe_n), .select_n_in(sel_w),
    .select_n_out(sel_out), .select_n_oe_n(sel_oe_n));
  smsp_slave_model u_slave (.sclk(sclk_w), .sel_n(sel_w), .mosi(mosi_w),
    .clock_idle_level(clock_idle_level), .sample_edge_select(sample_edge_select), .tx_byte(m_tx), .miso(m_miso),
    .rx_byte(m_rx), .bits(m_bits));
  // Clock generation
  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  // Shift clock edge monitor, mid-cycle away from launches
  always @(negedge hclk) begin
    cyc = cyc + 1;
    if (sclk_w !== sclk_q) begin
      if (edges == 0) first = cyc;
      last = cyc;
      edges = edges + 1;
    end
    sclk_q = sclk_w;
  end
  // Compare and count
  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  // One single AHB-Lite transfer
  task automatic ahb(input logic wr, input logic [ADDR_W-1:0] a,
                     input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr <= a;
    hwrite <= wr;
    hsize <= 3'b010;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rdv = hrdata;
  endtask : ahb
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] exp,
                    input string name);
    ahb(1'b0, a, 32'h0);
    check(name, rdv, {24'h0, exp});
  endtask : rd
  function automatic logic [7:0] rev(input logic [7:0] v);
    return {v[0], v[1], v[2], v[3], v[4], v[5], v[6], v[7]};
  endfunction : rev
  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : stop_test
  // Watchdog
  initial begin
    repeat (80000) @(posedge hclk);
    bad_count++;
    stop_test();
  end
  // Main sequence
  initial begin
    {hsel, hwrite, haddr, htrans, hsize, hwdata} = '0;
    {clock_idle_level, sample_edge_select, edges, cyc, first, last} = '0;
    {bad_count, samples_checked} = '0;
    tb_sel_n = 1'b1;
    sclk_q = 1'b0;
    m_tx = 8'h00;
    hresetn = 1'b0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(CTRL_ADDR, CTRL_RESET, "ctrl reset");
    rd(STAT_ADDR, STAT_RESET, "stat reset");
    rd(DATA_ADDR, DATA_RESET, "data reset");
    rd(12'h010, 8'h00, "unmapped");
    ahb(1'b1, STAT_ADDR, 32'h08);
    // Master transfers in every clock format and rate
    for (int m = 0; m < 4; m++) begin
      logic lsb;
      logic [7:0] tx, sb, st;
      lsb = (m == 3);
      tx = 8'hB1 + 8'(m * 37);
      sb = 8'h4E - 8'(m * 19);
      clock_idle_level <= m[1];
      sample_edge_select <= m[0];
      m_tx <= sb;
      ahb(1'b1, CTRL_ADDR, {24'h0, 2'b11, lsb, 1'b1, m[1], m[0], m[1:0]});
      rd(CTRL_ADDR, {2'b11, lsb, 1'b1, m[1], m[0], m[1:0]}, "ctrl rw");
      edges = 0;
      ahb(1'b1, DATA_ADDR, {24'h0, tx});
      if (m == 0) ahb(1'b1, DATA_ADDR, 32'hFF);
      st = 8'h00;
      for (int n = 0; n < 1000 && st[7] !== 1'b1; n++) begin
        ahb(1'b0, STAT_ADDR, 32'h0);
        st = rdv[7:0];
      end
      @(posedge hclk);
      check("status", st, (m == 0) ? 8'hC8 : 8'h88);
      check("edges", edges, 16);
      check("span", last - first, 15 * dv[m] / 2);
      check("idle level", sclk_w, m[1]);
      check("slave bits", m_bits, 8);
      check("slave rx", m_rx, lsb ? rev(tx) : tx);
      check("select idle", sel_w, 1'b1);
      rd(DATA_ADDR, lsb ? rev(sb) : sb, "read buffer");
      edges = 0;
      ahb(1'b1, DATA_ADDR, 32'h00);
      repeat (30) @(posedge hclk);
      check("refused write", edges, 0);
      ahb(1'b1, STAT_ADDR, 32'h08);
    end
    // Mode fault with detection enabled
    ahb(1'b1, STAT_ADDR, 32'h00);
    ahb(1'b1, CTRL_ADDR, 32'hD0);
    @(posedge hclk);
    check("select oe", sel_oe_n, 1'b1);
    tb_sel_n <= 1'b0;
    repeat (4) @(posedge hclk);
    rd(STAT_ADDR, 8'h10, "fault flag");
    tb_sel_n <= 1'b1;
    ahb(1'b1, STAT_ADDR, 32'h08);
    // Slave role pin directions
    ahb(1'b1, CTRL_ADDR, 32'h40);
    @(posedge hclk);
    check("mosi oe", mosi_oe_n, 1'b1);
    check("sclk oe", sck_oe_n, 1'b1);
    check("miso oe idle", miso_oe_n, 1'b1);
    tb_sel_n <= 1'b0;
    repeat (4) @(posedge hclk);
    check("miso oe sel", miso_oe_n, 1'b0);
    tb_sel_n <= 1'b1;
    // Disabled master does nothing
    ahb(1'b1, CTRL_ADDR, 32'h10);
    edges = 0;
    ahb(1'b1, DATA_ADDR, 32'h5A);
    repeat (30) @(posedge hclk);
    check("disabled", edges, 0);
    check("disabled oe", sck_oe_n, 1'b1);
    stop_test();
  end
endmodule : testbench
